// ==== logic/fault_mgr.sv ====
/*
 * fault_mgr: fault handling of a two-switch, two-regulator power chip.
 * takes live comparator levels, keeps sticky status flags, drives
 * the active-low fault pin, the two power-good outputs, switch closes and
 * regulator modes. registers sit on a classic 32-bit Wishbone slave.
 * assumes comparator outputs are asynchronous levels, high while true.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - 12V undervolt: flag, irq, open 12V switch
// - 5V undervolt: flag, irq, open 5V switch
// - 12V clamping: flag, irq, all stays on
// - 5V clamping: flag, irq, all stays on
// - 12V limit filtered 1.024ms: flag, irq
// - 5V limit filtered 1.024ms: flag, irq
// - low rail under 90%: flag, pgood low, recovery
// - mid rail under 90%: flag, pgood low, recovery
// - low rail short: flag, pgood low, hiccup
// - mid rail short: flag, pgood low, hiccup
// - rail limit filtered 32us: flag, irq
// - rail overcurrent never locks other flags
// - 5V thermal warning filtered 32us: flag, irq
// - 12V thermal warning filtered 32us: flag, irq
// - irq pin low until firmware clears all
// - pgood rises after 1ms quiet, falls instantly
module fault_mgr #(
    parameter int unsigned ILIM_CYCLES = fault_mgr_pkg::ILIM_CYCLES,
    parameter int unsigned PG_CYCLES   = fault_mgr_pkg::PG_CYCLES
) (
    // clock and reset
    input  wire logic                                 REF_CLK_I,
    input  wire logic                                 RESET_N_I,
    // comparator detections, asynchronous
    input  wire logic [fault_mgr_pkg::NUM_SENSE-1:0]  SENSE_I,
    // wishbone slave
    input  wire logic                                 WB_CYC_I,
    input  wire logic                                 WB_STB_I,
    input  wire logic                                 WB_WE_I,
    input  wire logic [3:0]                           WB_ADR_I,
    input  wire logic [3:0]                           WB_SEL_I,
    input  wire logic [31:0]                          WB_DAT_I,
    output logic      [31:0]                          WB_DAT_O,
    output logic                                      WB_ACK_O,
    // interrupts
    output logic                                      FAULT_IRQ_N_O,
    output logic                                      IRQ_O,
    // power good
    output logic                                      PGOOD_LOW_RAIL_O,
    output logic                                      PGOOD_MID_RAIL_O,
    // switches and regulators
    output logic                                      SW12_CLOSE_O,
    output logic                                      SW5_CLOSE_O,
    output logic                                      LOWRAIL_EN_O,
    output logic                                      MIDRAIL_EN_O,
    output logic      [1:0]                           LOWRAIL_MODE_O,
    output logic      [1:0]                           MIDRAIL_MODE_O
);

    // ========================================================
    // helpers

    // filtered detections and the length of their filter
    function automatic logic is_filtered(input int unsigned idx);
        is_filtered = (idx == fault_mgr_pkg::SW12_OVERCUR)
                   || (idx == fault_mgr_pkg::SW5_OVERCUR)
                   || (idx == fault_mgr_pkg::LOWRAIL_OVERCUR)
                   || (idx == fault_mgr_pkg::MIDRAIL_OVERCUR)
                   || (idx == fault_mgr_pkg::SW5_THERM_WARN)
                   || (idx == fault_mgr_pkg::SW12_THERM_WARN);
    endfunction

    function automatic logic [fault_mgr_pkg::CNT_W-1:0] filt_len(input int unsigned idx);
        if ((idx == fault_mgr_pkg::SW12_OVERCUR) || (idx == fault_mgr_pkg::SW5_OVERCUR))
        begin
            filt_len = fault_mgr_pkg::CNT_W'(ILIM_CYCLES);
        end
        else
        begin
            filt_len = fault_mgr_pkg::CNT_W'(fault_mgr_pkg::WARN_CYCLES);
        end
    endfunction

    // regulator mode from its undervolt and short levels
    function automatic logic [1:0] rail_mode(input logic under, input logic short_c);
        if (short_c)
        begin
            rail_mode = fault_mgr_pkg::MODE_HICCUP;
        end
        else if (under)
        begin
            rail_mode = fault_mgr_pkg::MODE_RECOVERY;
        end
        else
        begin
            rail_mode = fault_mgr_pkg::MODE_NORMAL;
        end
    endfunction

    // ========================================================
    // input synchronisers
    // a level moves only once stages two and three agree

    logic [fault_mgr_pkg::NUM_SENSE-1:0] sync1_r;
    logic [fault_mgr_pkg::NUM_SENSE-1:0] sync2_r;
    logic [fault_mgr_pkg::NUM_SENSE-1:0] sync3_r;
    logic [fault_mgr_pkg::NUM_SENSE-1:0] level_r;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            level_r <= '0;
        end
        else
        begin
            sync1_r <= SENSE_I;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r));
        end
    end

    // ========================================================
    // short detection: below 70% while the rail is in current limit

    logic low_short;
    logic mid_short;

    assign low_short = level_r[fault_mgr_pkg::LOWRAIL_BELOW70]
                     & level_r[fault_mgr_pkg::LOWRAIL_OVERCUR];
    assign mid_short = level_r[fault_mgr_pkg::MIDRAIL_BELOW70]
                     & level_r[fault_mgr_pkg::MIDRAIL_OVERCUR];

    // ========================================================
    // event qualification, one lane per flag

    logic [fault_mgr_pkg::NUM_FLAGS-1:0] event_c;

    genvar g;
    generate
        for (g = 0; g < fault_mgr_pkg::NUM_FLAGS; g = g + 1)
        begin : lane
            if (is_filtered(g))
            begin : filt
                // counter restarts on any drop, so a glitchy limit never qualifies
                logic [fault_mgr_pkg::CNT_W-1:0] cnt_r;
                always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
                begin
                    if (!RESET_N_I)
                    begin
                        cnt_r <= '0;
                    end
                    else if (!level_r[g])
                    begin
                        cnt_r <= '0;
                    end
                    else if (cnt_r != filt_len(g))
                    begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                assign event_c[g] = level_r[g] && (cnt_r == filt_len(g));
            end
            else if (g == fault_mgr_pkg::LOWRAIL_UNDER)
            begin : lowuv
                assign event_c[g] = level_r[g] | low_short;
            end
            else if (g == fault_mgr_pkg::MIDRAIL_UNDER)
            begin : miduv
                assign event_c[g] = level_r[g] | mid_short;
            end
            else
            begin : direct
                assign event_c[g] = level_r[g];
            end
        end
    endgenerate

    // ========================================================
    // wishbone slave

    logic        bus_req;
    logic        wr_stb;
    logic [31:0] wr_mask;
    logic [31:0] rd_data;

    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_stb  = bus_req & WB_WE_I;
    assign wr_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

    // one wait state: ack the cycle after the request is seen
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= bus_req && !WB_WE_I ? rd_data : 32'h0000_0000;
        end
    end

    // ========================================================
    // status and mask

    logic [fault_mgr_pkg::NUM_FLAGS-1:0] status_r;
    logic [fault_mgr_pkg::NUM_FLAGS-1:0] mask_r;
    logic [fault_mgr_pkg::NUM_FLAGS-1:0] clear_c;

    assign clear_c = (wr_stb && WB_ADR_I == fault_mgr_pkg::ADDR_STATUS)
                   ? (WB_DAT_I[fault_mgr_pkg::NUM_FLAGS-1:0]
                      & wr_mask[fault_mgr_pkg::NUM_FLAGS-1:0])
                   : '0;

    // no flag locks the register: rail overcurrent included, every
    // later fault still records; a set in the clearing cycle wins
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            status_r <= fault_mgr_pkg::STATUS_RESET;
        end
        else
        begin
            status_r <= (status_r & ~clear_c) | event_c;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            mask_r <= fault_mgr_pkg::MASK_RESET;
        end
        else if (wr_stb && WB_ADR_I == fault_mgr_pkg::ADDR_MASK)
        begin
            mask_r <= (mask_r & ~wr_mask[fault_mgr_pkg::NUM_FLAGS-1:0])
                    | (WB_DAT_I[fault_mgr_pkg::NUM_FLAGS-1:0]
                       & wr_mask[fault_mgr_pkg::NUM_FLAGS-1:0]);
        end
    end

    // fault pin ignores the mask: firmware must clear every flag to release it
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            FAULT_IRQ_N_O <= 1'b1;
            IRQ_O         <= 1'b0;
        end
        else
        begin
            FAULT_IRQ_N_O <= ~|((status_r & ~clear_c) | event_c);
            IRQ_O         <= |(((status_r & ~clear_c) | event_c) & mask_r);
        end
    end

    // ========================================================
    // read mux

    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (WB_ADR_I)
            fault_mgr_pkg::ADDR_STATUS:
            begin
                rd_data[fault_mgr_pkg::NUM_FLAGS-1:0] = status_r;
            end
            fault_mgr_pkg::ADDR_MASK:
            begin
                rd_data[fault_mgr_pkg::NUM_FLAGS-1:0] = mask_r;
            end
            fault_mgr_pkg::ADDR_LIVE:
            begin
                rd_data[fault_mgr_pkg::NUM_SENSE-1:0] = level_r;
            end
            fault_mgr_pkg::ADDR_RAILS:
            begin
                rd_data[7:0] = {PGOOD_MID_RAIL_O, PGOOD_LOW_RAIL_O, MIDRAIL_MODE_O,
                                LOWRAIL_MODE_O, SW5_CLOSE_O, SW12_CLOSE_O};
            end
            default:
            begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // ========================================================
    // power good, one timer per rail

    logic [1:0] rail_low_c;
    logic [1:0] pgood_c;

    assign rail_low_c[0] = event_c[fault_mgr_pkg::LOWRAIL_UNDER];
    assign rail_low_c[1] = event_c[fault_mgr_pkg::MIDRAIL_UNDER];

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : pg
            // timer restarts on every dip, so power good needs a full quiet window
            logic [fault_mgr_pkg::CNT_W-1:0] tmr_r;
            logic                            good_r;
            always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
            begin
                if (!RESET_N_I)
                begin
                    tmr_r  <= '0;
                    good_r <= 1'b0;
                end
                else if (rail_low_c[g])
                begin
                    tmr_r  <= '0;
                    good_r <= 1'b0;
                end
                else if (tmr_r != fault_mgr_pkg::CNT_W'(PG_CYCLES))
                begin
                    tmr_r  <= tmr_r + 1'b1;
                end
                else
                begin
                    good_r <= 1'b1;
                end
            end
            assign pgood_c[g] = good_r;
        end
    endgenerate

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            PGOOD_LOW_RAIL_O <= 1'b0;
            PGOOD_MID_RAIL_O <= 1'b0;
        end
        else
        begin
            PGOOD_LOW_RAIL_O <= pgood_c[0];
            PGOOD_MID_RAIL_O <= pgood_c[1];
        end
    end

    // ========================================================
    // switches and regulators
    // clamping, current limit and warnings never open a switch

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            SW12_CLOSE_O <= 1'b0;
            SW5_CLOSE_O  <= 1'b0;
        end
        else
        begin
            SW12_CLOSE_O <= ~level_r[fault_mgr_pkg::IN12_UNDERVOLT];
            SW5_CLOSE_O  <= ~level_r[fault_mgr_pkg::IN5_UNDERVOLT];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            LOWRAIL_EN_O   <= 1'b0;
            MIDRAIL_EN_O   <= 1'b0;
            LOWRAIL_MODE_O <= fault_mgr_pkg::MODE_NORMAL;
            MIDRAIL_MODE_O <= fault_mgr_pkg::MODE_NORMAL;
        end
        else
        begin
            // regulators stay enabled through every fault handled here
            LOWRAIL_EN_O   <= 1'b1;
            MIDRAIL_EN_O   <= 1'b1;
            LOWRAIL_MODE_O <= rail_mode(level_r[fault_mgr_pkg::LOWRAIL_UNDER],
                                        low_short);
            MIDRAIL_MODE_O <= rail_mode(level_r[fault_mgr_pkg::MIDRAIL_UNDER],
                                        mid_short);
        end
    end

endmodule

// ==== logic/fault_mgr_pkg.sv ====
/*
 * fault_mgr_pkg: constants shared by the fault manager and its bench.
 * assumes a 100 MHz reference clock and a 32-bit classic Wishbone bus.
 */
package fault_mgr_pkg;

    // ========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned ILIM_FILT_NS   = 1024000;
    localparam int unsigned WARN_FILT_NS   = 32000;
    localparam int unsigned PG_DELAY_NS    = 1000000;
    localparam int unsigned ILIM_CYCLES    = ILIM_FILT_NS / CLK_PERIOD_NS;
    localparam int unsigned WARN_CYCLES    = WARN_FILT_NS / CLK_PERIOD_NS;
    localparam int unsigned PG_CYCLES      = PG_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 17;
    localparam int unsigned SYNC_DEPTH     = 3;

    // ========================================================
    // sensor and status bit positions
    localparam int unsigned NUM_SENSE      = 14;
    localparam int unsigned NUM_FLAGS      = 12;
    localparam int unsigned IN12_UNDERVOLT = 0;
    localparam int unsigned IN5_UNDERVOLT  = 1;
    localparam int unsigned IN12_OVERVOLT  = 2;
    localparam int unsigned IN5_OVERVOLT   = 3;
    localparam int unsigned SW12_OVERCUR   = 4;
    localparam int unsigned SW5_OVERCUR    = 5;
    localparam int unsigned LOWRAIL_UNDER  = 6;
    localparam int unsigned MIDRAIL_UNDER  = 7;
    localparam int unsigned LOWRAIL_OVERCUR = 8;
    localparam int unsigned MIDRAIL_OVERCUR = 9;
    localparam int unsigned SW5_THERM_WARN = 10;
    localparam int unsigned SW12_THERM_WARN = 11;
    localparam int unsigned LOWRAIL_BELOW70 = 12;
    localparam int unsigned MIDRAIL_BELOW70 = 13;

    // ========================================================
    // register map (byte addresses) and reset values
    localparam logic [3:0]  ADDR_STATUS    = 4'h0;
    localparam logic [3:0]  ADDR_MASK      = 4'h4;
    localparam logic [3:0]  ADDR_LIVE      = 4'h8;
    localparam logic [3:0]  ADDR_RAILS     = 4'hC;
    localparam logic [11:0] STATUS_RESET   = 12'h000;
    localparam logic [11:0] MASK_RESET     = 12'h000;

    // ========================================================
    // regulator operating modes
    localparam logic [1:0]  MODE_NORMAL    = 2'h0;
    localparam logic [1:0]  MODE_RECOVERY  = 2'h1;
    localparam logic [1:0]  MODE_HICCUP    = 2'h2;

endpackage

// ==== sim/fault_mgr_bench.sv ====
/* fault_mgr_bench: self-checking bench for the fault manager.
   assumes the firmware model and the monitor are compiled before it. */
`timescale 1ns/1ps
module fault_mgr_bench;
    localparam int ILIM = 20;
    localparam int PGC  = 30;
    localparam int WARN = fault_mgr_pkg::WARN_CYCLES;
    localparam logic [3:0] A_ST = fault_mgr_pkg::ADDR_STATUS;
    localparam logic [3:0] A_MK = fault_mgr_pkg::ADDR_MASK;
    localparam logic [3:0] A_RL = fault_mgr_pkg::ADDR_RAILS;
    logic        clk, rst_n, cyc, stb, we, ack, irq_n, irq, pgl, pgm, sw12, sw5;
    logic [13:0] sense_r;
    logic [3:0]  adr, sel;
    logic [31:0] dwr, drd;
    int          miscompares, tests_run;
    int          fq[$] = '{0, 1, 2, 3, 6, 7};
    int          filt[$] = '{4, 5, 8, 9, 10, 11};
    fault_mgr #(.ILIM_CYCLES(ILIM), .PG_CYCLES(PGC)) fault_mgr_inst (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .SENSE_I(sense_r), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dwr),
        .WB_DAT_O(drd), .WB_ACK_O(ack), .FAULT_IRQ_N_O(irq_n), .IRQ_O(irq),
        .PGOOD_LOW_RAIL_O(pgl), .PGOOD_MID_RAIL_O(pgm), .SW12_CLOSE_O(sw12),
        .SW5_CLOSE_O(sw5), .LOWRAIL_EN_O(), .MIDRAIL_EN_O(), .LOWRAIL_MODE_O(),
        .MIDRAIL_MODE_O());
    host_fw_model fw_inst (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(dwr), .dat_i(drd), .ack_i(ack));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ========================================
    // model and helpers
    function automatic logic [31:0] rails(logic [13:0] s, logic pl, logic pm);
        logic [1:0] lm, mm;
        lm = (s[12] & s[8]) ? 2'h2 : {1'b0, s[6]};
        mm = (s[13] & s[9]) ? 2'h2 : {1'b0, s[7]};
        return {24'h0, pm, pl, mm, lm, ~s[1], ~s[0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic drive(input logic [13:0] s);
        @(posedge clk);
        sense_r <= s;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        fw_inst.xfer(1'b0, a, 4'hF, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        fw_inst.xfer(1'b1, a, s, d, q);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ========================================
    // tests
    initial
    begin
        logic [13:0] s;
        logic [31:0] m, rm;
        logic [3:0]  sl;
        int          b, n;
        miscompares = 0;
        tests_run = 0;
        sense_r = 14'h0;
        rst_n = 1'b0;
        b = $urandom(32'h0CC4805D);
        tick(20);
        rst_n <= 1'b1;
        tick(PGC + 6);
        rdc(A_ST, {20'h0, fault_mgr_pkg::STATUS_RESET});
        rdc(A_MK, {20'h0, fault_mgr_pkg::MASK_RESET});
        wr(fault_mgr_pkg::ADDR_LIVE, 4'hF, 32'hFFFFFFFF);
        wr(A_RL, 4'hF, 32'hFFFFFFFF);
        rdc(fault_mgr_pkg::ADDR_LIVE, 32'h0);
        rdc(A_RL, rails(14'h0, 1'b1, 1'b1));
        $display("test reset done");
        foreach (fq[i])
        begin
            b = fq[i];
            s = 14'h1 << b;
            drive(s);
            tick(10);
            rdc(A_ST, 32'h1 << b);
            rdc(A_RL, rails(s, b != 6, b != 7));
            drive(14'h0);
            tick(PGC - 2);
            chk({30'h0, pgm, pgl}, {30'h0, b != 7, b != 6});
            rdc(A_ST, 32'h1 << b);
            chk({31'h0, irq_n}, 32'h0);
            fw_inst.clear_flags(12'h1 << b);
            tick(12);
            chk({29'h0, irq_n, pgm, pgl}, 32'h7);
        end
        $display("test latched faults done");
        for (int r = 0; r < 2; r++)
        begin
            s = r[0] ? 14'h2200 : 14'h1100;
            drive(s);
            tick(10);
            rdc(A_ST, r[0] ? 32'h80 : 32'h40);
            rdc(A_RL, rails(s, r[0], ~r[0]));
            drive(14'h0);
            tick(8);
            fw_inst.clear_flags(12'hFFF);
            tick(PGC + 10);
        end
        $display("test shorts done");
        foreach (filt[i])
        begin
            b = filt[i];
            n = (b < 6) ? ILIM : WARN;
            s = 14'h1 << b;
            drive(s);
            tick(n - 4);
            drive(14'h0);
            tick(8);
            rdc(A_ST, 32'h0);
            drive(s);
            tick(n + 10);
            rdc(A_ST, 32'h1 << b);
            chk({28'h0, pgm, pgl, sw5, sw12}, 32'hF);
            drive(s | 14'h1);
            tick(10);
            rdc(A_ST, (32'h1 << b) | 32'h1);
            drive(14'h0);
            tick(8);
            fw_inst.clear_flags(12'hFFF);
            rdc(A_ST, 32'h0);
        end
        $display("test filtered faults done");
        rm = 32'h0;
        repeat (4)
        begin
            m = $urandom;
            sl = 4'($urandom);
            wr(A_MK, sl, m);
            for (int k = 0; k < 2; k++)
                if (sl[k]) rm[k*8 +: 8] = m[k*8 +: 8];
            rm[31:12] = 20'h0;
            rdc(A_MK, rm);
        end
        wr(A_MK, 4'hF, 32'h1);
        drive(14'h1);
        tick(10);
        chk({30'h0, irq, irq_n}, 32'h2);
        drive(14'h0);
        tick(8);
        wr(A_MK, 4'hF, 32'h2);
        tick(2);
        chk({30'h0, irq, irq_n}, 32'h0);
        fw_inst.clear_flags(12'hFFF);
        tick(2);
        chk({30'h0, irq, irq_n}, 32'h1);
        $display("test interrupt mask done");
        conclude();
    end
    initial
    begin
        tick(60000);
        miscompares++;
        conclude();
    end
endmodule

bind fault_mgr fault_mgr_monitor #(.ILIM_CYCLES(ILIM_CYCLES), .PG_CYCLES(PG_CYCLES)) mon_inst (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .SENSE_I(SENSE_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O),
    .FAULT_IRQ_N_O(FAULT_IRQ_N_O), .PGOOD_LOW_RAIL_O(PGOOD_LOW_RAIL_O),
    .PGOOD_MID_RAIL_O(PGOOD_MID_RAIL_O), .SW12_CLOSE_O(SW12_CLOSE_O),
    .SW5_CLOSE_O(SW5_CLOSE_O), .LOWRAIL_EN_O(LOWRAIL_EN_O), .MIDRAIL_EN_O(MIDRAIL_EN_O),
    .LOWRAIL_MODE_O(LOWRAIL_MODE_O));

// ==== sim/fault_mgr_monitor.sv ====
/* fault_mgr_monitor: port checks for the fault manager.
   assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/1ps
module fault_mgr_monitor #(
    parameter int unsigned ILIM_CYCLES = fault_mgr_pkg::ILIM_CYCLES,
    parameter int unsigned PG_CYCLES   = fault_mgr_pkg::PG_CYCLES
) (
    // clock and reset
    input wire logic        REF_CLK_I,
    input wire logic        RESET_N_I,
    // watched inputs
    input wire logic [13:0] SENSE_I,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_ADR_I,
    // watched outputs
    input wire logic        WB_ACK_O,
    input wire logic        FAULT_IRQ_N_O,
    input wire logic        PGOOD_LOW_RAIL_O,
    input wire logic        PGOOD_MID_RAIL_O,
    input wire logic        SW12_CLOSE_O,
    input wire logic        SW5_CLOSE_O,
    input wire logic        LOWRAIL_EN_O,
    input wire logic        MIDRAIL_EN_O,
    input wire logic [1:0]  LOWRAIL_MODE_O
);
    // ========================================
    // helper counters
    localparam int unsigned WARN = fault_mgr_pkg::WARN_CYCLES;
    int unsigned quiet_r;
    int unsigned ilim_r;
    int unsigned warn_r;
    logic        clear_req;
    // quiet counts at the pins, so it runs ahead of the synchronised level unless a one-cycle pin pulse resets it
    assign clear_req = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I[3:2] == 2'b00;
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            quiet_r <= 0;
            ilim_r  <= 0;
            warn_r  <= 0;
        end
        else
        begin
            quiet_r <= (SENSE_I[6] || (SENSE_I[12] && SENSE_I[8])) ? 0 : quiet_r + 1;
            ilim_r  <= SENSE_I[4] ? ilim_r + 1 : 0;
            warn_r  <= SENSE_I[10] ? warn_r + 1 : 0;
        end
    end
    // ========================================
    // held conditions
    default clocking mon_cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    sequence in12_undervolt_flag_s;
        SENSE_I[0] [*8];
    endsequence
    sequence in5_ok_s;
        (!SENSE_I[1]) [*8];
    endsequence
    sequence fault_s;
        (|{SENSE_I[7:6], SENSE_I[3:0]}) [*8];
    endsequence
    sequence low_short_s;
        (SENSE_I[12] && SENSE_I[8]) [*8];
    endsequence
    // ========================================
    // checks
    sw12_open_a: assert property (in12_undervolt_flag_s |-> !SW12_CLOSE_O)
        else $error("12V switch closed during input undervoltage");
    sw5_kept_a: assert property (in5_ok_s |-> SW5_CLOSE_O)
        else $error("5V switch open with good input");
    irq_set_a: assert property (fault_s |-> !FAULT_IRQ_N_O)
        else $error("fault pin high during a fault");
    irq_hold_a: assert property (!FAULT_IRQ_N_O && !clear_req && !$past(clear_req)
        |=> !FAULT_IRQ_N_O) else $error("fault pin released without a clear");
    pg_low_a: assert property ((SENSE_I[6]) [*8] |-> !PGOOD_LOW_RAIL_O)
        else $error("low rail power good high while under");
    pg_mid_a: assert property ((SENSE_I[7]) [*8] |-> !PGOOD_MID_RAIL_O)
        else $error("mid rail power good high while under");
    pg_wait_a: assert property ($rose(PGOOD_LOW_RAIL_O) |-> quiet_r >= PG_CYCLES)
        else $error("power good rose before the quiet time");
    hiccup_mode_a: assert property (low_short_s
        |-> LOWRAIL_MODE_O == fault_mgr_pkg::MODE_HICCUP) else $error("short without hiccup");
    recovery_mode_a: assert property ((SENSE_I[6] && !SENSE_I[12]) [*8]
        |-> LOWRAIL_MODE_O == fault_mgr_pkg::MODE_RECOVERY) else $error("no recovery mode");
    rails_on_a: assert property ($past(RESET_N_I) |-> LOWRAIL_EN_O && MIDRAIL_EN_O)
        else $error("regulator disabled");
    ilim_filt_a: assert property (ilim_r == ILIM_CYCLES + 8 |-> !FAULT_IRQ_N_O)
        else $error("switch limit not flagged after filter");
    warn_filt_a: assert property (warn_r == WARN + 8 |-> !FAULT_IRQ_N_O)
        else $error("thermal warning not flagged after filter");
endmodule

// ==== sim/host_fw_model.sv ====
/* host_fw_model: firmware side, a classic Wishbone master.
   assumes a slave that acks every request; write data is scrambled when idle. */
`timescale 1ns/1ps
module host_fw_model (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [3:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 4'h0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // ========================================
    // one bus cycle; waits on the ack for as long as it takes, the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        dat_o <= ~d;
    endtask
    // ========================================
    // release the fault pin by writing ones to the flags
    task automatic clear_flags(input logic [11:0] f);
        logic [31:0] q;
        xfer(1'b1, fault_mgr_pkg::ADDR_STATUS, 4'hF, {20'h0, f}, q);
    endtask
endmodule
